//--- pad_config_regs.svh
// register map, field positions and reset values for the pad configuration bank
// assumes a 32-bit apb slave with word-aligned byte addresses
`ifndef PAD_CONFIG_REGS_SVH
`define PAD_CONFIG_REGS_SVH

// number of pads in the bank and width of a pad index
`define PAD_COUNT 6
`define PAD_INDEX_W 3

// byte offsets of the pad registers
`define PAD23_CONFIG_OFFSET 12'h05c
`define PAD24_CONFIG_OFFSET 12'h060
`define PAD25_CONFIG_OFFSET 12'h064
`define PAD26_CONFIG_OFFSET 12'h068
`define PAD27_CONFIG_OFFSET 12'h06c
`define PAD28_CONFIG_OFFSET 12'h070
`define PAD_FIRST_OFFSET `PAD23_CONFIG_OFFSET
`define PAD_LAST_OFFSET `PAD28_CONFIG_OFFSET
`define PAD_ADDR_W 12

// stored width: bits 12:0, everything above reads zero
`define PAD_CFG_W 13

// field positions
`define PAD_FUNC_LSB 0
`define PAD_FUNC_MSB 1
`define PAD_SRC_LSB 3
`define PAD_SRC_MSB 4
`define PAD_OEN_BIT 5
`define PAD_PULL_LSB 6
`define PAD_PULL_MSB 7
`define PAD_DRIVE_LSB 8
`define PAD_DRIVE_MSB 9
`define PAD_SLEW_BIT 10
`define PAD_REN_BIT 11
`define PAD_SMT_BIT 12

// writable bits (bit 2 unused) and reset value: oen=1, drive=1, rest zero
`define PAD_CFG_WR_MASK 13'h1ffb
`define PAD_CFG_RESET 13'h0120

`endif

//--- pad_config_pkg.sv
// types shared by the pad configuration bank
// assumes pad_config_regs.svh for widths
`include "pad_config_regs.svh"

package pad_config_pkg;

    // one stored pad register
    typedef logic [`PAD_CFG_W-1:0] pad_cfg_t;

    // source of a pad's output control
    typedef enum logic [1:0] {
        src_local = 2'h0,
        src_other = 2'h1,
        src_fabric = 2'h2,
        src_reserved = 2'h3
    } ctrl_source_e;

    // undriven pad condition
    typedef enum logic [1:0] {
        pull_none = 2'h0,
        pull_up = 2'h1,
        pull_down = 2'h2,
        pull_keeper = 2'h3
    } pull_mode_e;

    // apb phase tracker, gray along idle -> data
    typedef enum logic [0:0] {
        apb_idle = 1'h0,
        apb_data = 1'h1
    } apb_state_e;

endpackage : pad_config_pkg

//--- pad_config_store.sv
// storage of the pad registers with a registered read port
// assumes the caller masks write data and checks index range
`timescale 1ns/1ps
`include "pad_config_regs.svh"

module pad_config_store (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // write port
    input wire logic wr_en,
    input wire logic [`PAD_INDEX_W-1:0] wr_index,
    input wire pad_config_pkg::pad_cfg_t wr_data,
    // read port, data registered
    input wire logic rd_en,
    input wire logic rd_valid,
    input wire logic [`PAD_INDEX_W-1:0] rd_index,
    output pad_config_pkg::pad_cfg_t rd_data,
    // every word in parallel, for the pad outputs
    output pad_config_pkg::pad_cfg_t words [`PAD_COUNT]
);

    // one flop bank per pad
    genvar g;
    generate
        for (g = 0; g < `PAD_COUNT; g++) begin : g_word
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    words[g] <= `PAD_CFG_RESET;
                end else if (wr_en && int'(wr_index) == g) begin
                    words[g] <= wr_data;
                end
            end
        end
    endgenerate

    // read data held until the next read; unmapped reads give zero
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rd_data <= '0;
        end else if (rd_en) begin
            rd_data <= rd_valid ? words[rd_index] : '0;
        end
    end

endmodule : pad_config_store

//--- pad_config_registers.sv
// apb register bank configuring pads 23 to 28 and the output mux for each pad
// assumes apb3 master with synchronous inputs on pclk; pad cells sit outside
//
// Operation
// - two-bit function select in bits 1:0
// - bits 4:3 pick local, other or fabric control
// - bit 5 active-low driver enable under local control, resets one
// - bits 7:6 pad state: z, up, down, keeper
// - bits 9:8 drive strength code, resets one
// - bit 10 fast slew when set
// - bit 11 receiver enable, resets off
// - bit 12 schmitt trigger enable, resets off
`timescale 1ns/1ps
`include "pad_config_regs.svh"

module pad_config_registers (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [`PAD_ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // peripheral outputs, four candidates per pad
    input wire logic [3:0] periph_out [`PAD_COUNT],
    input wire logic [`PAD_COUNT-1:0] periph_oen_n,
    // other internal sources
    input wire logic [`PAD_COUNT-1:0] other_out,
    input wire logic [`PAD_COUNT-1:0] other_oen_n,
    // programmable fabric
    input wire logic [`PAD_COUNT-1:0] fabric_out,
    input wire logic [`PAD_COUNT-1:0] fabric_oen_n,
    // pad input path
    input wire logic [`PAD_COUNT-1:0] pad_in,
    output logic [`PAD_COUNT-1:0] pad_in_gated,
    // pad cell controls
    output logic [`PAD_COUNT-1:0] pad_out,
    output logic [`PAD_COUNT-1:0] pad_driver_enable_n,
    output logic [1:0] pad_function_select [`PAD_COUNT],
    output logic [1:0] pad_ctrl_source [`PAD_COUNT],
    output logic [1:0] pad_pull_mode [`PAD_COUNT],
    output logic [1:0] pad_drive_strength [`PAD_COUNT],
    output logic [`PAD_COUNT-1:0] pad_slew_fast,
    output logic [`PAD_COUNT-1:0] pad_receive_enable,
    output logic [`PAD_COUNT-1:0] pad_hysteresis_enable
);

    // address decode, shared by the read and write paths
    function automatic logic addr_hit(input logic [`PAD_ADDR_W-1:0] addr);
        addr_hit = (addr[1:0] == 2'h0) && (addr >= `PAD_FIRST_OFFSET)
            && (addr <= `PAD_LAST_OFFSET);
    endfunction : addr_hit

    // word index from a byte address inside the bank
    function automatic logic [`PAD_INDEX_W-1:0] addr_index(
        input logic [`PAD_ADDR_W-1:0] addr
    );
        logic [`PAD_ADDR_W-1:0] rel;
        rel = addr - `PAD_FIRST_OFFSET;
        addr_index = rel[`PAD_INDEX_W+1:2];
    endfunction : addr_index

    pad_config_pkg::apb_state_e state;
    pad_config_pkg::apb_state_e next_state;
    pad_config_pkg::pad_cfg_t words [`PAD_COUNT];
    pad_config_pkg::pad_cfg_t rd_data;
    pad_config_pkg::pad_cfg_t wr_data;
    logic setup_phase;
    logic access_phase;
    logic hit;
    logic wr_en;
    logic [`PAD_INDEX_W-1:0] index;

    // apb phases; the read is fetched in setup so access needs no wait
    assign setup_phase = psel && !penable;
    assign access_phase = psel && penable;
    assign hit = addr_hit(paddr);
    assign index = addr_index(paddr);

    // phase tracker: data is ready once a setup edge has been seen
    always_comb begin
        next_state = state;
        case (state)
            pad_config_pkg::apb_idle: begin
                if (setup_phase) begin
                    next_state = pad_config_pkg::apb_data;
                end
            end
            pad_config_pkg::apb_data: begin
                if (access_phase) begin
                    next_state = pad_config_pkg::apb_idle;
                end
            end
            default: begin
                next_state = pad_config_pkg::apb_idle;
            end
        endcase
    end

    // state register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state <= pad_config_pkg::apb_idle;
        end else begin
            state <= next_state;
        end
    end

    // one wait-free access phase after every setup
    assign pready = access_phase && (state == pad_config_pkg::apb_data);
    // unmapped addresses answer with an error, writes are dropped
    assign pslverr = pready && !hit;

    // writes take effect on the completing edge; unused bits never stored
    assign wr_en = pready && pwrite && hit;
    assign wr_data = pwdata[`PAD_CFG_W-1:0] & `PAD_CFG_WR_MASK;

    pad_config_store u_store (
        .pclk(pclk),
        .presetn(presetn),
        .wr_en(wr_en),
        .wr_index(index),
        .wr_data(wr_data),
        .rd_en(setup_phase && !pwrite),
        .rd_valid(hit),
        .rd_index(index),
        .rd_data(rd_data),
        .words(words)
    );

    // upper bits of the bus word read as zero
    assign prdata = {{(32 - `PAD_CFG_W){1'b0}}, rd_data};

    // per-pad field outputs and output mux
    genvar g;
    generate
        for (g = 0; g < `PAD_COUNT; g++) begin : g_pad
            logic [1:0] func;
            logic [1:0] src;
            logic local_oen_n;
            logic next_out;
            logic next_oen_n;

            // field taps straight from the stored flops
            assign func = words[g][`PAD_FUNC_MSB:`PAD_FUNC_LSB];
            assign src = words[g][`PAD_SRC_MSB:`PAD_SRC_LSB];
            assign local_oen_n = words[g][`PAD_OEN_BIT];

            // static pad cell controls, flop outputs with no extra delay
            assign pad_function_select[g] = func;
            assign pad_ctrl_source[g] = src;
            assign pad_pull_mode[g] = words[g][`PAD_PULL_MSB:`PAD_PULL_LSB];
            assign pad_drive_strength[g] = words[g][`PAD_DRIVE_MSB:`PAD_DRIVE_LSB];
            assign pad_slew_fast[g] = words[g][`PAD_SLEW_BIT];
            assign pad_receive_enable[g] = words[g][`PAD_REN_BIT];
            assign pad_hysteresis_enable[g] = words[g][`PAD_SMT_BIT];

            // control source select; the reserved code parks the driver off
            // so a bad write never fights an external driver
            always_comb begin
                next_out = 1'b0;
                next_oen_n = 1'b1;
                case (pad_config_pkg::ctrl_source_e'(src))
                    pad_config_pkg::src_local: begin
                        // register bit 5 and the peripheral enable both gate the driver, func picks the data
                        next_out = periph_out[g][func];
                        next_oen_n = local_oen_n | periph_oen_n[g];
                    end
                    pad_config_pkg::src_other: begin
                        next_out = other_out[g];
                        next_oen_n = other_oen_n[g];
                    end
                    pad_config_pkg::src_fabric: begin
                        next_out = fabric_out[g];
                        next_oen_n = fabric_oen_n[g];
                    end
                    default: begin
                        next_out = 1'b0;
                        next_oen_n = 1'b1;
                    end
                endcase
            end

            // registered pad data and enable; one cycle of latency traded
            // for glitch-free pad controls
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    pad_out[g] <= 1'b0;
                    pad_driver_enable_n[g] <= 1'b1;
                end else begin
                    pad_out[g] <= next_out;
                    pad_driver_enable_n[g] <= next_oen_n;
                end
            end

            // receiver gating: a disabled receiver reads low, not floating
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    pad_in_gated[g] <= 1'b0;
                end else begin
                    pad_in_gated[g] <= pad_in[g] & words[g][`PAD_REN_BIT];
                end
            end
        end
    endgenerate

endmodule : pad_config_registers

//--- pad_sources_model.sv
// peripheral, fabric and pad sources feeding the pad bank
// assumes only the bank clock; levels change right after each rising edge
`timescale 1ns/1ps
`include "pad_config_regs.svh"
module pad_sources_model (
    // clock
    input wire logic pclk,
    // source and pad levels
    output logic [3:0] periph_out [`PAD_COUNT],
    output logic [`PAD_COUNT-1:0] periph_oen_n,
    output logic [`PAD_COUNT-1:0] other_out,
    output logic [`PAD_COUNT-1:0] other_oen_n,
    output logic [`PAD_COUNT-1:0] fabric_out,
    output logic [`PAD_COUNT-1:0] fabric_oen_n,
    output logic [`PAD_COUNT-1:0] pad_in
);
    // fresh levels every cycle, so a stale mux path cannot match by luck
    task automatic fill;
        foreach (periph_out[k]) periph_out[k] <= 4'($urandom);
        {periph_oen_n, other_out, other_oen_n} <= 18'($urandom);
        {fabric_out, fabric_oen_n, pad_in} <= 18'($urandom);
    endtask : fill
    initial fill();
    always @(posedge pclk) fill();
endmodule : pad_sources_model

//--- pad_config_checker.sv
// bus and field assertions for the pad bank
// assumes a bind onto pad_config_registers
`timescale 1ns/1ps
module pad_config_checker (
    // clock, reset, bus
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // pad side
    input wire logic [5:0] pad_in,
    input wire logic [5:0] pad_in_gated,
    input wire logic [5:0] pad_slew_fast,
    input wire logic [5:0] pad_receive_enable,
    input wire logic [5:0] pad_hysteresis_enable
);
    default clocking @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    logic wr, bad;
    // completed write, and an address outside the bank
    assign wr = pready && pwrite;
    assign bad = paddr < 12'h05c || paddr > 12'h070 || paddr[1:0] != 2'h0;
    ready_zero_wait_a: assert property (psel && penable && $past(psel && !penable) |-> pready)
        else $error("ready late");
    err_unmapped_a: assert property (pready && bad |-> pslverr)
        else $error("no error");
    err_mapped_a: assert property (pready && !bad |-> !pslverr)
        else $error("false error");
    read_spare_a: assert property (pready && !pwrite |->
        prdata[31:13] == 19'h0 && !prdata[2]) else $error("spare bits set");
    rx_gate_a: assert property (pad_in_gated == $past(pad_in & pad_receive_enable))
        else $error("rx gate");
    slew_write_a: assert property (wr && paddr == 12'h05c |=>
        pad_slew_fast[0] == $past(pwdata[10])) else $error("slew");
    slew_hold_a: assert property (!wr |=> $stable(pad_slew_fast))
        else $error("slew moved");
    ren_write_a: assert property (wr && paddr == 12'h060 |=>
        pad_receive_enable[1] == $past(pwdata[11])) else $error("rx enable");
    hyst_write_a: assert property (wr && paddr == 12'h070 |=>
        pad_hysteresis_enable[5] == $past(pwdata[12])) else $error("hysteresis");
    cover property (wr && !bad);
    cover property (pready && !pwrite && !bad);
    cover property (pslverr);
endmodule : pad_config_checker
bind pad_config_registers pad_config_checker pad_config_checker_i (.pclk, .presetn, .psel,
    .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .pad_in, .pad_in_gated,
    .pad_slew_fast, .pad_receive_enable, .pad_hysteresis_enable);

//--- pad_config_registers_tb.sv
// self-checking bench for the pad configuration bank
// assumes the source model and checker compile first
`timescale 1ns/1ps
`include "pad_config_regs.svh"
module pad_config_registers_tb;
    // set in its declaration so time zero brings no false falling edge
    logic pclk = 1'h0;
    logic presetn, psel, penable, pwrite, pready, pslverr, err, armed;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, q;
    logic [3:0] periph_out [6];
    logic [5:0] periph_oen_n, other_out, other_oen_n, fabric_out, fabric_oen_n, pad_in;
    logic [5:0] pad_in_gated, pad_out, pad_driver_enable_n, exp_out, exp_oen_n, exp_gated;
    logic [5:0] pad_slew_fast, pad_receive_enable, pad_hysteresis_enable;
    logic [1:0] pad_function_select [6], pad_ctrl_source [6], pad_pull_mode [6];
    logic [1:0] pad_drive_strength [6];
    pad_config_pkg::pad_cfg_t mirror [6];
    logic [11:0] outside [5] = '{12'h058, 12'h074, 12'h062, 12'h000, 12'hffc};
    int failures, total_checks;
    pad_config_registers pad_config_registers_i (.pclk, .presetn, .psel, .penable, .pwrite,
        .paddr, .pwdata, .prdata, .pready, .pslverr, .periph_out, .periph_oen_n, .other_out,
        .other_oen_n, .fabric_out, .fabric_oen_n, .pad_in, .pad_in_gated, .pad_out,
        .pad_driver_enable_n, .pad_function_select, .pad_ctrl_source, .pad_pull_mode,
        .pad_drive_strength, .pad_slew_fast, .pad_receive_enable, .pad_hysteresis_enable);
    pad_sources_model pad_sources_model_i (.pclk, .periph_out, .periph_oen_n, .other_out,
        .other_oen_n, .fabric_out, .fabric_oen_n, .pad_in);
    initial begin
        forever #10 pclk = ~pclk;
    end
    function automatic logic mapped(input logic [11:0] a);
        return a >= `PAD_FIRST_OFFSET && a <= `PAD_LAST_OFFSET && a[1:0] == 2'h0;
    endfunction : mapped
    function automatic int idx(input logic [11:0] a);
        return int'((a - `PAD_FIRST_OFFSET) >> 2);
    endfunction : idx
    // expected {data, enable_n} of pad k, reserved source parks the driver
    function automatic logic [1:0] exp_pad(input int k);
        case (mirror[k][4:3])
            2'h0: return {periph_out[k][mirror[k][1:0]], mirror[k][5] | periph_oen_n[k]};
            2'h1: return {other_out[k], other_oen_n[k]};
            2'h2: return {fabric_out[k], fabric_oen_n[k]};
            default: return 2'h1;
        endcase
    endfunction : exp_pad
    function automatic logic [12:0] fields(input int k);
        return {pad_hysteresis_enable[k], pad_receive_enable[k], pad_slew_fast[k],
            pad_drive_strength[k], pad_pull_mode[k], 1'h0, pad_ctrl_source[k], 1'h0,
            pad_function_select[k]};
    endfunction : fields
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            failures++;
            $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    // one apb transfer, waiting on pready under a bound
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        int n;
        logic rdy;
        @(posedge pclk);
        psel <= 1'h1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'h1;
        n = 0;
        // answer taken mid-cycle: pready drops in the completing edge's own step
        do begin
            @(negedge pclk);
            rdy = pready;
            q = prdata;
            err = pslverr;
            @(posedge pclk);
            n++;
        end while (rdy !== 1'h1 && n < 20);
        if (rdy !== 1'h1) begin
            failures++;
            end_sim();
        end
        psel <= 1'h0;
        penable <= 1'h0;
        if (wr && mapped(a)) mirror[idx(a)] = d[12:0] & `PAD_CFG_WR_MASK;
    endtask : apb
    task automatic wr_rd(input logic [11:0] a, input logic [31:0] d);
        apb(1'h1, a, d);
        chk(32'(err), 32'(!mapped(a)));
        apb(1'h0, a, 32'h0);
        chk(q, mapped(a) ? {19'h0, mirror[idx(a)]} : 32'h0);
    endtask : wr_rd
    // pad side lags registers and sources by one edge
    always @(negedge pclk) begin
        if (armed) begin
            chk(32'(pad_out), 32'(exp_out));
            chk(32'(pad_driver_enable_n), 32'(exp_oen_n));
            chk(32'(pad_in_gated), 32'(exp_gated));
        end
        for (int k = 0; k < 6; k++) begin
            chk(32'(fields(k)), 32'(mirror[k] & 13'h1fdb));
            {exp_out[k], exp_oen_n[k]} = exp_pad(k);
            exp_gated[k] = pad_in[k] & mirror[k][11];
        end
        armed = presetn;
    end
    task automatic end_sim;
        $display("checks %0d failures %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask : end_sim
    initial begin
        repeat (5000) @(posedge pclk);
        failures++;
        end_sim();
    end
    initial begin
        {presetn, psel, penable, pwrite, paddr, pwdata, armed} = '0;
        {failures, total_checks} = '0;
        foreach (mirror[k]) mirror[k] = `PAD_CFG_RESET;
        void'($urandom(81117));
        repeat (2) @(posedge pclk);
        presetn <= 1'h1;
        // reset value of every pad
        for (int k = 0; k < 6; k++) begin
            apb(1'h0, `PAD_FIRST_OFFSET + 12'(4 * k), 32'h0);
            chk(q, 32'h0000_0120);
        end
        // every source, pull and drive code; odd codes also set single bits and junk
        for (int v = 0; v < 4; v++) begin
            for (int k = 0; k < 6; k++) begin
                wr_rd(`PAD_FIRST_OFFSET + 12'(4 * k),
                    32'(v) * 32'h149 | (v[0] ? 32'hffff_fc24 : 32'h0));
                repeat (3) @(posedge pclk);
            end
        end
        // addresses outside the bank
        foreach (outside[i]) wr_rd(outside[i], 32'hffff_ffff);
        // random traffic across and beside the bank
        repeat (60) wr_rd(12'h058 + 12'(4 * ($urandom % 8)), $urandom);
        end_sim();
    end
endmodule : pad_config_registers_tb
